// file: pkg/iepf_pkg.sv
// Constants for the interrupt enable, priority and flag block.
package iepf_pkg;
    localparam logic [7:0] ADDR_EXT_EVENT_FLAGS = 8'h91;
    localparam logic [7:0] ADDR_IRQ_ENABLE = 8'hA8;
    localparam logic [7:0] ADDR_IRQ_PRIORITY = 8'hB8;
    localparam logic [7:0] ADDR_EXT_IRQ_CONTROL = 8'hD8;
    localparam logic [7:0] ADDR_EXT_IRQ_ENABLE = 8'hE8;
    localparam logic [7:0] ADDR_EXT_IRQ_PRIORITY = 8'hF8;
    // Bit positions.
    localparam int GLOBAL_GATE_BIT = 7;
    localparam int WAKEUP_FLAG_BIT = 3;
    localparam int CONV_FLAG_BIT = 4;
    // Writable masks and forced-one masks per register.
    localparam logic [7:0] IE_WMASK = 8'hBF;
    localparam logic [7:0] IP_WMASK = 8'h3F;
    localparam logic [7:0] IP_ONES = 8'h80;
    localparam logic [7:0] FLAGS_ONES = 8'h08;
    localparam logic [7:0] CTRL_ONES = 8'h40;
    localparam logic [7:0] EXT_WMASK = 8'h1F;
    localparam logic [7:0] EXT_ONES = 8'hE0;
    localparam logic [7:0] REG_RESET = 8'h00;
    // Source count and vector index encoding (natural order, 0 is highest).
    localparam int NUM_SRC = 11;
    localparam logic [3:0] NO_SOURCE = 4'hF;
endpackage : iepf_pkg

// file: design/iepf_ctrl.sv
// Interrupt enable, priority and extended flag registers with request arbitration.
//
// Notes on behaviour
// - Enable bits 4..0 gate serial, timer1, pin1, timer0, pin0 sources.
// - Serial enable passes either transmit-done or receive-done flag.
// - Priority bits 5..0 select high or low level for standard sources.
// - Flag bit 7 sets on radio channel two ready rising edge; sticky.
// - Flag bit 6 sets on radio channel one ready rising edge; sticky.
// - Flag bit 5 sets when the serial peripheral finishes a byte.
// - Flag bit 4 sets on converter end-of-conversion rising edge; sticky.
// - Hardware never clears extended flags; only software writing zero does.
// - Software writing one to a flag sets it and requests like hardware.
// - Wakeup flag sets on its event and re-requests until software clears it.
// - Software writing one to the wakeup flag requests its interrupt.
// - Extended enable bit 4 gates the wakeup timer interrupt.
// - Extended enable bits 3..0 gate radio two, radio one, serial, converter.
// - Extended priority bit 4 sets wakeup timer level.
// - Extended priority bits 3..0 set radio, serial, converter levels.
// - Reserved ones: priority 7, flag 3, control 6, ext enable/priority 7..5.
// - Reserved zeros: priority 6, flags 2..0, control 5,4,2..0; control 7 unused.
// - Global gate bit 7 blocks all interrupts when clear.
// - Enable bit 5 gates timer 2 on overflow or external flag.
// - Level beats natural order; only a higher level preempts a running routine.
`timescale 1ns/10ps
`default_nettype none
module iepf_ctrl
    import iepf_pkg::*;
(
    input wire logic clock,                 // CPU clock
    input wire logic rst_n,                 // synchronous reset, active low
    input wire logic [7:0] sfr_addr,        // special function register address
    input wire logic sfr_wr,                // write strobe
    input wire logic sfr_rd,                // read strobe
    input wire logic [7:0] sfr_wdata,       // write data
    output logic [7:0] sfr_rdata,           // read data, registered
    output logic sfr_hit,                   // read address belongs to this block, registered
    input wire logic ext_pin0_flag,         // external pin 0 request flag
    input wire logic timer0_overflow,       // timer 0 flag
    input wire logic ext_pin1_flag,         // external pin 1 request flag
    input wire logic timer1_overflow,       // timer 1 flag
    input wire logic serial_tx_done,        // serial transmit complete
    input wire logic serial_rx_done,        // serial receive complete
    input wire logic timer2_overflow,       // timer 2 overflow flag
    input wire logic timer2_external_flag,  // timer 2 external flag
    input wire logic conv_done,             // converter end-of-conversion level
    input wire logic spi_byte_done,         // one-cycle pulse, byte finished
    input wire logic radio_ch1_data_ready,  // radio channel one ready level
    input wire logic radio_ch2_data_ready,  // radio channel two ready level
    input wire logic wakeup_event,          // one-cycle pulse, wakeup timer event
    input wire logic isr_enter,             // CPU vectors to granted source
    input wire logic isr_return,            // CPU executes return from interrupt
    output logic irq_req,                   // request to CPU
    output logic [3:0] irq_index            // natural order index of winner
);
    logic [7:0] irq_enable;
    logic [5:0] irq_priority;
    logic [3:0] ext_flags;
    logic wakeup_flag;
    logic [4:0] ext_irq_enable;
    logic [4:0] ext_irq_priority;
    logic conv_q, ch1_q, ch2_q;
    logic [1:0] active_lvl;
    logic [NUM_SRC-1:0] pend, en_src, prio_src;
    logic [3:0] next_index;
    logic next_req, next_high;

    function automatic logic wr_to(input logic [7:0] a);
        wr_to = sfr_wr && (sfr_addr == a);
    endfunction : wr_to

    function automatic logic [3:0] pick(input logic [NUM_SRC-1:0] v);
        pick = NO_SOURCE;
        for (int i = NUM_SRC - 1; i >= 0; i--) begin
            if (v[i]) begin
                pick = 4'(i);
            end
        end
    endfunction : pick

    always_ff @(posedge clock) begin
        if (!rst_n) begin
            conv_q <= 1'b0;
            ch1_q <= 1'b0;
            ch2_q <= 1'b0;
        end else begin
            conv_q <= conv_done;
            ch1_q <= radio_ch1_data_ready;
            ch2_q <= radio_ch2_data_ready;
        end
    end

    logic [3:0] hw_set;
    assign hw_set = {radio_ch2_data_ready & ~ch2_q, radio_ch1_data_ready & ~ch1_q,
                     spi_byte_done, conv_done & ~conv_q};

    // Write strobes as variables, so that the assertions sample settled values.
    logic wr_flags, wr_enable, wr_control;
    always_comb begin
        wr_flags = wr_to(ADDR_EXT_EVENT_FLAGS);
        wr_enable = wr_to(ADDR_IRQ_ENABLE);
        wr_control = wr_to(ADDR_EXT_IRQ_CONTROL);
    end

    // flags cleared only by software write.
    always_ff @(posedge clock) begin
        if (!rst_n) begin
            ext_flags <= 4'h0;
        end else begin
            if (wr_to(ADDR_EXT_EVENT_FLAGS)) begin
                ext_flags <= sfr_wdata[7:4] | hw_set;
            end else begin
                ext_flags <= ext_flags | hw_set;
            end
        end
    end

    // wakeup flag stays until software clears it.
    always_ff @(posedge clock) begin
        if (!rst_n) begin
            wakeup_flag <= 1'b0;
        end else if (wr_to(ADDR_EXT_IRQ_CONTROL)) begin
            wakeup_flag <= sfr_wdata[WAKEUP_FLAG_BIT] | wakeup_event;
        end else begin
            wakeup_flag <= wakeup_flag | wakeup_event;
        end
    end

    always_ff @(posedge clock) begin
        if (!rst_n) begin
            irq_enable <= REG_RESET;
            irq_priority <= 6'h00;
            ext_irq_enable <= 5'h00;
            ext_irq_priority <= 5'h00;
        end else begin
            if (wr_to(ADDR_IRQ_ENABLE)) begin
                irq_enable <= sfr_wdata & IE_WMASK;
            end
            if (wr_to(ADDR_IRQ_PRIORITY)) begin
                irq_priority <= sfr_wdata[5:0];
            end
            if (wr_to(ADDR_EXT_IRQ_ENABLE)) begin
                ext_irq_enable <= sfr_wdata[4:0];
            end
            if (wr_to(ADDR_EXT_IRQ_PRIORITY)) begin
                ext_irq_priority <= sfr_wdata[4:0];
            end
        end
    end

    always_ff @(posedge clock) begin
        if (!rst_n) begin
            sfr_rdata <= 8'h00;
            sfr_hit <= 1'b0;
        end else begin
            sfr_hit <= sfr_rd && (sfr_addr == ADDR_EXT_EVENT_FLAGS ||
                       sfr_addr == ADDR_IRQ_ENABLE || sfr_addr == ADDR_IRQ_PRIORITY ||
                       sfr_addr == ADDR_EXT_IRQ_CONTROL || sfr_addr == ADDR_EXT_IRQ_ENABLE ||
                       sfr_addr == ADDR_EXT_IRQ_PRIORITY);
            case (sfr_addr)
                ADDR_EXT_EVENT_FLAGS: sfr_rdata <= {ext_flags, 4'h0} | FLAGS_ONES;
                ADDR_IRQ_ENABLE: sfr_rdata <= irq_enable;
                ADDR_IRQ_PRIORITY: sfr_rdata <= {2'b00, irq_priority} | IP_ONES;
                ADDR_EXT_IRQ_CONTROL: sfr_rdata <= {4'h0, wakeup_flag, 3'h0} | CTRL_ONES;
                ADDR_EXT_IRQ_ENABLE: sfr_rdata <= {3'h0, ext_irq_enable} | EXT_ONES;
                ADDR_EXT_IRQ_PRIORITY: sfr_rdata <= {3'h0, ext_irq_priority} | EXT_ONES;
                default: sfr_rdata <= 8'h00;
            endcase
        end
    end

    // Sources in natural order: pin0, t0, pin1, t1, serial, t2, conv, spi, radio1, radio2, wakeup.
    // serial and timer 2 either flag.
    assign pend = {wakeup_flag, ext_flags[3], ext_flags[2], ext_flags[1], ext_flags[0],
                   timer2_overflow | timer2_external_flag, serial_tx_done | serial_rx_done,
                   timer1_overflow, ext_pin1_flag, timer0_overflow, ext_pin0_flag};
    assign en_src = {ext_irq_enable, irq_enable[5:0]}
                    & {NUM_SRC{irq_enable[GLOBAL_GATE_BIT]}} & pend;
    assign prio_src = {ext_irq_priority, irq_priority};

    // level first, then natural order, preempt only a lower level.
    always_comb begin
        next_high = |(en_src & prio_src);
        next_index = next_high ? pick(en_src & prio_src) : pick(en_src & ~prio_src);
        next_req = next_high ? (active_lvl != 2'd2) : ((|en_src) && active_lvl == 2'd0);
    end

    // active level tracking: 0 none, 1 low, 2 high.
    always_ff @(posedge clock) begin
        if (!rst_n) begin
            active_lvl <= 2'd0;
        end else if (isr_enter && irq_req) begin
            active_lvl <= next_high ? 2'd2 : 2'd1;
        end else if (isr_return) begin
            active_lvl <= 2'd0;
        end
    end

    always_ff @(posedge clock) begin
        if (!rst_n) begin
            irq_req <= 1'b0;
            irq_index <= NO_SOURCE;
        end else begin
            irq_req <= next_req;
            irq_index <= next_req ? next_index : NO_SOURCE;
        end
    end

    a_flag_sticky: assert property (@(posedge clock) disable iff (!rst_n)
        $fell(ext_flags[0]) |-> $past(wr_flags))
        else $error("extended flag cleared without a write");
    a_edge_sets_flag: assert property (@(posedge clock) disable iff (!rst_n)
        (conv_done && !conv_q) |=> ext_flags[0])
        else $error("converter edge did not set flag");
    a_radio2_edge: assert property (@(posedge clock) disable iff (!rst_n)
        (radio_ch2_data_ready && !ch2_q) |=> ext_flags[3])
        else $error("radio two edge did not set flag");
    a_radio1_edge: assert property (@(posedge clock) disable iff (!rst_n)
        (radio_ch1_data_ready && !ch1_q) |=> ext_flags[2])
        else $error("radio one edge did not set flag");
    a_spi_sets_flag: assert property (@(posedge clock) disable iff (!rst_n)
        spi_byte_done |=> ext_flags[1])
        else $error("byte done did not set flag");
    a_sw_flag_set: assert property (@(posedge clock) disable iff (!rst_n)
        (wr_flags && sfr_wdata[7]) |=> ext_flags[3])
        else $error("software write of one did not set flag");
    a_set_beats_clear: assert property (@(posedge clock) disable iff (!rst_n)
        (wr_flags && spi_byte_done) |=> ext_flags[1])
        else $error("spi event lost against clear");
    a_level_edge_once: assert property (@(posedge clock) disable iff (!rst_n)
        (conv_done && conv_q && !ext_flags[0] && !wr_flags) |=> !ext_flags[0])
        else $error("held converter level set the flag again");
    a_wakeup_event_set: assert property (@(posedge clock) disable iff (!rst_n)
        wakeup_event |=> wakeup_flag)
        else $error("wakeup event did not set flag");
    a_wakeup_sticky: assert property (@(posedge clock) disable iff (!rst_n)
        (wakeup_flag && !wr_control) |=> wakeup_flag)
        else $error("wakeup flag dropped");
    a_sw_set_request: assert property (@(posedge clock) disable iff (!rst_n)
        (wakeup_flag && ext_irq_enable[4] && irq_enable[7] && active_lvl == 2'd0)
        |=> irq_req)
        else $error("enabled wakeup flag gave no request");

    a_global_gate: assert property (@(posedge clock) disable iff (!rst_n)
        !irq_enable[GLOBAL_GATE_BIT] |=> !irq_req)
        else $error("request with global gate clear");
    a_global_write: assert property (@(posedge clock) disable iff (!rst_n)
        (wr_enable && !sfr_wdata[GLOBAL_GATE_BIT]) |=> !irq_enable[GLOBAL_GATE_BIT])
        else $error("global gate not cleared by write");
    a_std_mask: assert property (@(posedge clock) disable iff (!rst_n)
        !irq_enable[0] |=> !(irq_req && irq_index == 4'd0))
        else $error("masked pin zero source requested");
    a_serial_either: assert property (@(posedge clock) disable iff (!rst_n)
        (irq_enable[7] && irq_enable[4] && serial_rx_done && active_lvl == 2'd0) |=> irq_req)
        else $error("serial receive flag gave no request");
    a_timer2_either: assert property (@(posedge clock) disable iff (!rst_n)
        (irq_enable[7] && irq_enable[5] && timer2_external_flag && active_lvl == 2'd0) |=> irq_req)
        else $error("timer two external flag gave no request");
    a_ext_mask: assert property (@(posedge clock) disable iff (!rst_n)
        !ext_irq_enable[0] |=> !(irq_req && irq_index == 4'd6))
        else $error("masked converter source requested");
    a_wakeup_mask: assert property (@(posedge clock) disable iff (!rst_n)
        !ext_irq_enable[4] |=> !(irq_req && irq_index == 4'd10))
        else $error("masked wakeup source requested");

    a_pin0_high_wins: assert property (@(posedge clock) disable iff (!rst_n)
        (en_src[0] && prio_src[0] && !active_lvl[1]) |=> irq_req && irq_index == 4'd0)
        else $error("high pin zero did not win");
    a_ext_high_wins: assert property (@(posedge clock) disable iff (!rst_n)
        (en_src[6] && prio_src[6] && ~|(en_src[5:0] & prio_src[5:0]) && !active_lvl[1])
        |=> irq_req && irq_index == 4'd6)
        else $error("high converter did not win");
    a_wakeup_low_held: assert property (@(posedge clock) disable iff (!rst_n)
        (active_lvl == 2'd1 && !prio_src[10]) |=> !(irq_req && irq_index == 4'd10))
        else $error("low wakeup preempted a low routine");
    a_low_held: assert property (@(posedge clock) disable iff (!rst_n)
        (active_lvl == 2'd1 && !(|(en_src & prio_src))) |=> !irq_req)
        else $error("low request preempted a low routine");
    a_high_preempt: assert property (@(posedge clock) disable iff (!rst_n)
        (active_lvl == 2'd2) |=> !irq_req)
        else $error("high routine preempted");
    a_index_idle: assert property (@(posedge clock) disable iff (!rst_n)
        !irq_req |-> irq_index == NO_SOURCE)
        else $error("index shown without a request");
    a_index_range: assert property (@(posedge clock) disable iff (!rst_n)
        irq_req |-> irq_index != NO_SOURCE)
        else $error("request without a winner");

    a_reserved_read: assert property (@(posedge clock) disable iff (!rst_n)
        (sfr_rd && sfr_addr == ADDR_EXT_IRQ_ENABLE) |=> sfr_rdata[7:5] == 3'b111)
        else $error("reserved ones read wrong");
    a_ext_prio_ones: assert property (@(posedge clock) disable iff (!rst_n)
        (sfr_addr == ADDR_EXT_IRQ_PRIORITY) |=> sfr_rdata[7:5] == 3'b111)
        else $error("reserved priority ones read wrong");
    a_ip_reserved: assert property (@(posedge clock) disable iff (!rst_n)
        (sfr_addr == ADDR_IRQ_PRIORITY) |=> sfr_rdata[7:6] == 2'b10)
        else $error("reserved priority bits read wrong");
    a_flags_reserved: assert property (@(posedge clock) disable iff (!rst_n)
        (sfr_addr == ADDR_EXT_EVENT_FLAGS) |=> sfr_rdata[3:0] == 4'h8)
        else $error("reserved flag bits read wrong");
    a_ie_bit6_zero: assert property (@(posedge clock) disable iff (!rst_n)
        (sfr_addr == ADDR_IRQ_ENABLE) |=> !sfr_rdata[6])
        else $error("enable bit six read as one");
    a_ctrl_reserved: assert property (@(posedge clock) disable iff (!rst_n)
        (sfr_addr == ADDR_EXT_IRQ_CONTROL) |=> (sfr_rdata & 8'hF7) == CTRL_ONES)
        else $error("reserved control bits read wrong");

    // Main scenarios.
    c_conv_irq: cover property (@(posedge clock) irq_req && irq_index == 4'd6);
    c_high_over_low: cover property (@(posedge clock) active_lvl == 2'd1 && irq_req);
    c_set_and_clear: cover property (@(posedge clock)
        wr_flags && |hw_set);
    c_wakeup_irq: cover property (@(posedge clock) irq_req && irq_index == 4'd10);
    c_high_nested: cover property (@(posedge clock) active_lvl == 2'd2);
endmodule : iepf_ctrl
`default_nettype wire

// file: tb/iepf_src_model.sv
// Event source model standing in for the converter, serial peripheral, radio and wakeup timer.
`timescale 1ns/10ps
`default_nettype none
module iepf_src_model (
    input wire logic clock,             // CPU clock
    input wire logic [4:0] fire,        // per source request from the bench
    output logic conv_done,             // converter end-of-conversion level
    output logic spi_byte_done,         // byte finished pulse
    output logic radio_ch1_data_ready,  // radio channel one ready level
    output logic radio_ch2_data_ready,  // radio channel two ready level
    output logic wakeup_event           // wakeup timer pulse
);
    logic [4:0] fire_q;
    initial {fire_q, conv_done, spi_byte_done, radio_ch1_data_ready} = '0;
    initial {radio_ch2_data_ready, wakeup_event} = '0;
    // Levels follow the request; pulses last one cycle from its start.
    always @(posedge clock) begin
        fire_q <= fire;
        conv_done <= fire[0];
        spi_byte_done <= fire[1] & ~fire_q[1];
        radio_ch1_data_ready <= fire[2];
        radio_ch2_data_ready <= fire[3];
        wakeup_event <= fire[4] & ~fire_q[4];
    end
endmodule : iepf_src_model
`default_nettype wire

// file: tb/tb_irq_enable_priority_flags.sv
// Self-checking bench for the interrupt enable, priority and flag block.
`timescale 1ns/10ps
`default_nettype none
module tb_irq_enable_priority_flags import iepf_pkg::*;;
    logic clock, rst_n, sfr_wr, sfr_rd, sfr_hit, irq_req, isr_enter, isr_return;
    logic [7:0] sfr_addr, sfr_wdata, sfr_rdata, std_flags, d;
    logic [3:0] irq_index;
    logic [4:0] fire;
    logic conv_done, spi_byte_done, radio_ch1_data_ready, radio_ch2_data_ready, wakeup_event;
    int fail_count, check_count;
    logic [7:0] ra [6] = '{ADDR_EXT_EVENT_FLAGS, ADDR_IRQ_ENABLE, ADDR_IRQ_PRIORITY,
        ADDR_EXT_IRQ_CONTROL, ADDR_EXT_IRQ_ENABLE, ADDR_EXT_IRQ_PRIORITY};
    logic [7:0] rst_exp [6] = '{FLAGS_ONES, REG_RESET, IP_ONES, CTRL_ONES, EXT_ONES, EXT_ONES};
    logic [7:0] ones_exp [6] = '{8'hF8, IE_WMASK, 8'hBF, 8'h48, 8'hFF, 8'hFF};
    logic [3:0] sel [8] = '{4'h0, 4'h1, 4'h2, 4'h3, 4'h4, 4'h4, 4'h5, 4'h5};
    iepf_ctrl iepf_ctrl_i (.clock(clock), .rst_n(rst_n), .sfr_addr(sfr_addr), .sfr_wr(sfr_wr),
        .sfr_rd(sfr_rd), .sfr_wdata(sfr_wdata), .sfr_rdata(sfr_rdata), .sfr_hit(sfr_hit),
        .ext_pin0_flag(std_flags[0]), .timer0_overflow(std_flags[1]),
        .ext_pin1_flag(std_flags[2]), .timer1_overflow(std_flags[3]),
        .serial_tx_done(std_flags[4]), .serial_rx_done(std_flags[5]),
        .timer2_overflow(std_flags[6]), .timer2_external_flag(std_flags[7]),
        .conv_done(conv_done), .spi_byte_done(spi_byte_done),
        .radio_ch1_data_ready(radio_ch1_data_ready), .radio_ch2_data_ready(radio_ch2_data_ready),
        .wakeup_event(wakeup_event), .isr_enter(isr_enter), .isr_return(isr_return),
        .irq_req(irq_req), .irq_index(irq_index));
    iepf_src_model iepf_src_model_i (.clock(clock), .fire(fire), .conv_done(conv_done),
        .spi_byte_done(spi_byte_done), .radio_ch1_data_ready(radio_ch1_data_ready),
        .radio_ch2_data_ready(radio_ch2_data_ready), .wakeup_event(wakeup_event));
    task automatic check(input logic [7:0] seen, input logic [7:0] exp);
        check_count++;
        if (seen !== exp) begin
            fail_count++;
            $display("MISMATCH t=%0t saw %h expected %h", $time, seen, exp);
        end
    endtask : check
    task automatic finish_test;
        $display("checks %0d mismatches %0d", check_count, fail_count);
        if (fail_count == 0 && check_count > 0) begin
            $display("== PASSED ==");
        end else begin
            $display("== FAILED ==");
        end
        $finish;
    endtask : finish_test
    task automatic wr(input logic [7:0] a, input logic [7:0] v);
        @(posedge clock);
        sfr_addr <= a;
        sfr_wdata <= v;
        sfr_wr <= 1'b1;
        @(posedge clock);
        sfr_wr <= 1'b0;
    endtask : wr
    task automatic rd(input logic [7:0] a, output logic [7:0] v);
        @(posedge clock);
        sfr_addr <= a;
        sfr_rd <= 1'b1;
        @(posedge clock);
        sfr_rd <= 1'b0;
        #1 v = sfr_rdata;
    endtask : rd
    // Waits a bounded time for the expected winner; running out ends the run.
    task automatic wait_irq(input logic [3:0] idx);
        int n;
        n = 0;
        while (!(irq_req === 1'b1 && irq_index === idx) && n < 12) begin
            @(posedge clock);
            #1 n++;
        end
        check({irq_req, 3'h0, irq_index}, {1'b1, 3'h0, idx});
        // A bound that ran out is already counted by the compare above.
        if (!(irq_req === 1'b1 && irq_index === idx)) begin
            finish_test();
        end
    endtask : wait_irq
    task automatic no_irq;
        repeat (4) @(posedge clock);
        #1 check({7'h00, irq_req}, 8'h00);
    endtask : no_irq
    initial begin
        clock = 1'b0;
        forever #4 clock = ~clock;
    end
    initial begin
        {rst_n, sfr_wr, sfr_rd, isr_enter, isr_return, fire} = '0;
        {sfr_addr, sfr_wdata, std_flags} = '0;
        fail_count = 0;
        check_count = 0;
        repeat (16) @(posedge clock);
        rst_n <= 1'b1;
        for (int i = 0; i < 6; i++) begin
            rd(ra[i], d);
            check(d, rst_exp[i]);
            check({7'h00, sfr_hit}, 8'h01);
            wr(ra[i], 8'hFF);
            rd(ra[i], d);
            check(d, ones_exp[i]);
        end
        for (int i = 0; i < 6; i++) wr(ra[i], 8'h00);
        rd(8'h90, d);
        check(d, 8'h00);
        check({7'h00, sfr_hit}, 8'h00);
        wr(ADDR_IRQ_ENABLE, 8'h80);
        wr(ADDR_EXT_IRQ_ENABLE, 8'h1F);
        for (int k = 0; k < 5; k++) begin
            @(posedge clock);
            fire[k] <= 1'b1;
            wait_irq(4'(6 + k));
            repeat (8) @(posedge clock);
            rd(k == 4 ? ADDR_EXT_IRQ_CONTROL : ADDR_EXT_EVENT_FLAGS, d);
            check(d, k == 4 ? 8'h48 : (8'h08 | (8'h10 << k)));
            wr(k == 4 ? ADDR_EXT_IRQ_CONTROL : ADDR_EXT_EVENT_FLAGS, 8'h00);
            fire[k] <= 1'b0;
            no_irq();
        end
        wr(ADDR_IRQ_ENABLE, 8'h00);
        wr(ADDR_EXT_EVENT_FLAGS, 8'h20);
        no_irq();
        wr(ADDR_IRQ_ENABLE, 8'h80);
        wait_irq(4'd7);
        wr(ADDR_EXT_EVENT_FLAGS, 8'h00);
        for (int j = 0; j < 8; j++) begin
            wr(ADDR_IRQ_ENABLE, 8'h80 | (8'h01 << sel[j]));
            std_flags <= 8'h01 << j;
            wait_irq(sel[j]);
            wr(ADDR_IRQ_ENABLE, 8'h80);
            no_irq();
            @(posedge clock);
            std_flags <= 8'h00;
        end
        @(posedge clock);
        std_flags <= 8'h01;
        wr(ADDR_IRQ_ENABLE, 8'h81);
        wr(ADDR_EXT_IRQ_ENABLE, 8'h01);
        wr(ADDR_EXT_EVENT_FLAGS, 8'h10);
        wait_irq(4'd0);
        wr(ADDR_EXT_IRQ_PRIORITY, 8'h01);
        wait_irq(4'd6);
        wr(ADDR_IRQ_PRIORITY, 8'h01);
        wait_irq(4'd0);
        wr(ADDR_EXT_EVENT_FLAGS, 8'h00);
        std_flags <= 8'h00;
        wr(ADDR_EXT_IRQ_ENABLE, 8'h10);
        wr(ADDR_EXT_IRQ_CONTROL, 8'h08);
        wait_irq(4'd10);
        @(posedge clock);
        isr_enter <= 1'b1;
        @(posedge clock);
        isr_enter <= 1'b0;
        no_irq();
        wr(ADDR_EXT_IRQ_ENABLE, 8'h11);
        wr(ADDR_EXT_EVENT_FLAGS, 8'h10);
        wait_irq(4'd6);
        @(posedge clock);
        isr_enter <= 1'b1;
        @(posedge clock);
        isr_enter <= 1'b0;
        no_irq();
        wr(ADDR_EXT_EVENT_FLAGS, 8'h00);
        @(posedge clock);
        isr_return <= 1'b1;
        @(posedge clock);
        isr_return <= 1'b0;
        wait_irq(4'd10);
        finish_test();
    end
endmodule : tb_irq_enable_priority_flags
`default_nettype wire
